// ===== hw/srt_map.svh
// register offsets, field positions, reset values and timing counts of the slew-rate trigger
`ifndef SRT_MAP_SVH
`define SRT_MAP_SVH

// ==========================================================================
// register byte offsets
`define SRT_OFS_CTRL      8'h00
`define SRT_OFS_THR_UP    8'h04
`define SRT_OFS_THR_LO    8'h08
`define SRT_OFS_DELTA     8'h0C
`define SRT_OFS_PRESET    8'h10
`define SRT_OFS_RATE      8'h14
`define SRT_OFS_STATUS    8'h18
`define SRT_OFS_TRIGCNT   8'h1C

// ==========================================================================
// field positions
`define SRT_CTRL_EN       0
`define SRT_CTRL_SRC      1
`define SRT_CTRL_POL      3
`define SRT_CTRL_SLOWER   5
`define SRT_PRESET_TTL    0
`define SRT_PRESET_ECL    1
`define SRT_STAT_MEAS     16
`define SRT_STAT_BUSY     17

// ==========================================================================
// polarity codes
`define SRT_POL_POS       2'h0
`define SRT_POL_NEG       2'h1
`define SRT_POL_EITHER    2'h2

// ==========================================================================
// reset values and threshold presets; thresholds in comparator dac codes, delta in clock cycles
`define SRT_RST_UP        16'hC000
`define SRT_RST_LO        16'h4000
`define SRT_RST_DELTA     16'h000A
`define SRT_TTL_UP        16'h9000
`define SRT_TTL_LO        16'h8200
`define SRT_ECL_UP        16'h7A00
`define SRT_ECL_LO        16'h7200

// ==========================================================================
// timing: transits under the fast limit are not resolved
`define SRT_CLK_PS        25000
`define SRT_FAST_PS       600
`define SRT_FAST_CYC_RAW  ((`SRT_FAST_PS + `SRT_CLK_PS - 1) / `SRT_CLK_PS)
`define SRT_FAST_CYC      ((`SRT_FAST_CYC_RAW < 1) ? 1 : `SRT_FAST_CYC_RAW)

// fraction bits of the reference rate readout
`define SRT_RATE_FRAC     16

`endif

// ===== hw/srt_pkg.sv
// types shared by the slew-rate trigger modules
package srt_pkg;

  typedef enum logic [1:0] {
    S_WAIT,
    S_RISE,
    S_FALL
  } srt_meas_e_t;

endpackage : srt_pkg

// ===== hw/srt_rate_if.sv
// carrier between the trigger core and the reference rate divider
interface srt_rate_if #(
  parameter int DW = 32,
  parameter int VW = 16
);
  logic          start;
  logic [DW-1:0] dividend;
  logic [VW-1:0] divisor;
  logic          busy;
  logic [DW-1:0] quotient;

  modport core (output start, output dividend, output divisor, input busy, input quotient);
  modport div  (input start, input dividend, input divisor, output busy, output quotient);
endinterface : srt_rate_if

// ===== hw/srt_sync.sv
// two-flop synchroniser for comparator pin inputs
module srt_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } srt_sync_t;

  srt_sync_t st;
  srt_sync_t next_st;

  // ========================================================================
  // per-bit stages; the first stage feeds only the second
  always_comb begin
    next_st = st;
    for (int i = 0; i < W; i++) begin
      next_st.s1[i] = d_i[i];
      next_st.s2[i] = st.s1[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;

endmodule : srt_sync

// ===== hw/srt_rate_div.sv
// restoring divider that derives the reference slew rate
module srt_rate_div #(
  parameter int DW = 32,
  parameter int VW = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  srt_rate_if.div   rif
);

  localparam int CNTW = $clog2(DW + 1);

  typedef struct packed {
    logic            busy;
    logic [CNTW-1:0] left;
    logic [VW:0]     rem;
    logic [DW-1:0]   dvd;
    logic [DW-1:0]   q;
  } srt_div_t;

  srt_div_t st;
  srt_div_t next_st;

  // ========================================================================
  // one quotient bit per cycle; a new start simply restarts the division
  always_comb begin
    logic [VW:0] trial;
    trial   = '0;
    next_st = st;
    if (rif.start) begin
      next_st.busy = 1'b1;
      next_st.left = CNTW'(DW);
      next_st.rem  = '0;
      next_st.dvd  = rif.dividend;
    end else if (st.busy) begin
      trial        = {st.rem[VW-1:0], st.dvd[DW-1]};
      next_st.dvd  = {st.dvd[DW-2:0], 1'b0};
      // a zero divisor always subtracts, so the rate saturates to all ones
      if (trial >= {1'b0, rif.divisor}) begin
        next_st.rem = trial - {1'b0, rif.divisor};
        next_st.q   = {st.q[DW-2:0], 1'b1};
      end else begin
        next_st.rem = trial;
        next_st.q   = {st.q[DW-2:0], 1'b0};
      end
      next_st.left = st.left - CNTW'(1);
      if (st.left == CNTW'(1)) begin
        next_st.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign rif.busy     = st.busy;
  assign rif.quotient = st.q;

endmodule : srt_rate_div

// ===== hw/srt_slew_trigger.sv
// slew-rate trigger qualifier with classic wishbone register slave
//
// Chosen here: the register offsets and the Wishbone register port.
`include "srt_map.svh"

module srt_slew_trigger #(
  parameter int NCH = 4,
  parameter int TW  = 16,
  parameter int CW  = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic [NCH-1:0] cmp_upper_i,
  input  wire logic [NCH-1:0] cmp_lower_i,
  output logic      [TW-1:0] thr_upper_o,
  output logic      [TW-1:0] thr_lower_o,
  output logic               trig_o,
  output logic               trig_falling_o
);

  localparam int DW   = TW + `SRT_RATE_FRAC;
  localparam int SW   = $clog2(NCH);
  localparam logic [CW-1:0] FAST_CYC = CW'(`SRT_FAST_CYC);

  // ========================================================================
  // level regions of the {upper, lower} comparator pair
  localparam logic [1:0] RG_BELOW = 2'h0;
  localparam logic [1:0] RG_MID   = 2'h1;
  localparam logic [1:0] RG_ABOVE = 2'h3;

  typedef struct packed {
    logic                ack;
    logic [31:0]         rdat;
    logic                en;
    logic [SW-1:0]       src;
    logic [1:0]          pol;
    logic                slower;
    logic [TW-1:0]       up;
    logic [TW-1:0]       lo;
    logic [CW-1:0]       delta;
    logic                rate_go;
    srt_pkg::srt_meas_e_t meas;
    logic [CW-1:0]       cnt;
    logic [CW-1:0]       last;
    logic [15:0]         ntrig;
    logic [1:0]          prev;
    logic                trig;
    logic                trig_fall;
  } srt_top_t;

  localparam srt_top_t RST = '{
    ack:       1'b0,
    rdat:      32'h0000_0000,
    en:        1'b0,
    src:       '0,
    pol:       `SRT_POL_POS,
    slower:    1'b0,
    up:        TW'(`SRT_RST_UP),
    lo:        TW'(`SRT_RST_LO),
    delta:     CW'(`SRT_RST_DELTA),
    rate_go:   1'b1,
    meas:      srt_pkg::S_WAIT,
    cnt:       '0,
    last:      '0,
    ntrig:     16'h0000,
    prev:      RG_BELOW,
    trig:      1'b0,
    trig_fall: 1'b0
  };

  srt_top_t st;
  srt_top_t next_st;

  logic [NCH-1:0] up_s;
  logic [NCH-1:0] lo_s;

  srt_rate_if #(.DW(DW), .VW(CW)) rif ();

  // ========================================================================
  // comparator pins cross into the clock domain before use
  srt_sync #(.W(2 * NCH)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({cmp_upper_i, cmp_lower_i}),
    .q_o   ({up_s, lo_s})
  );

  srt_rate_div #(.DW(DW), .VW(CW)) u_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .rif   (rif)
  );

  // ========================================================================
  // reference rate: span of the thresholds over delta, clamped at zero
  assign rif.start    = st.rate_go;
  assign rif.dividend = (st.up > st.lo) ? {st.up - st.lo, {`SRT_RATE_FRAC{1'b0}}} : '0;
  // read live: any delta write also restarts the division, so both stay coherent
  assign rif.divisor  = st.delta;

  function automatic logic [31:0] srt_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : srt_merge

  // ========================================================================
  // bus slave, edge qualifier and trigger
  always_comb begin
    logic        req;
    logic [7:0]  word;
    logic [31:0] wv;
    logic [31:0] ctrl_rd;
    logic [1:0]  cur;
    logic        rise_ok;
    logic        fall_ok;
    logic        hit;
    logic        abort;

    next_st = st;
    req     = wb_cyc_i & wb_stb_i & ~st.ack;
    word    = {wb_adr_i[7:2], 2'h0};
    wv      = 32'h0000_0000;
    ctrl_rd = 32'h0000_0000;
    hit     = 1'b0;
    abort   = 1'b0;
    cur     = RG_BELOW;
    rise_ok = 1'b0;
    fall_ok = 1'b0;

    ctrl_rd[`SRT_CTRL_EN]           = st.en;
    ctrl_rd[`SRT_CTRL_SRC +: SW]    = st.src;
    ctrl_rd[`SRT_CTRL_POL +: 2]     = st.pol;
    ctrl_rd[`SRT_CTRL_SLOWER]       = st.slower;

    next_st.ack     = req;
    // read data is zero outside the ack cycle
    next_st.rdat    = 32'h0000_0000;
    next_st.rate_go = 1'b0;
    next_st.trig      = 1'b0;
    next_st.trig_fall = 1'b0;

    // ----- register access: one ack per request, unmapped reads zero
    if (req && wb_we_i) begin
      unique case (word)
        `SRT_OFS_CTRL: begin
          wv             = srt_merge(ctrl_rd, wb_dat_i, wb_sel_i);
          next_st.en     = wv[`SRT_CTRL_EN];
          next_st.src    = wv[`SRT_CTRL_SRC +: SW];
          next_st.pol    = wv[`SRT_CTRL_POL +: 2];
          next_st.slower = wv[`SRT_CTRL_SLOWER];
          // a half-timed edge must not be judged against new settings
          abort          = 1'b1;
        end
        `SRT_OFS_THR_UP: begin
          wv              = srt_merge(32'(st.up), wb_dat_i, wb_sel_i);
          next_st.up      = wv[TW-1:0];
          next_st.rate_go = 1'b1;
        end
        `SRT_OFS_THR_LO: begin
          wv              = srt_merge(32'(st.lo), wb_dat_i, wb_sel_i);
          next_st.lo      = wv[TW-1:0];
          next_st.rate_go = 1'b1;
        end
        `SRT_OFS_DELTA: begin
          wv              = srt_merge(32'(st.delta), wb_dat_i, wb_sel_i);
          next_st.delta   = wv[CW-1:0];
          next_st.rate_go = 1'b1;
        end
        `SRT_OFS_PRESET: begin
          // ttl wins when both presets are requested at once
          if (wb_sel_i[0] && wb_dat_i[`SRT_PRESET_TTL]) begin
            next_st.up      = TW'(`SRT_TTL_UP);
            next_st.lo      = TW'(`SRT_TTL_LO);
            next_st.rate_go = 1'b1;
          end else if (wb_sel_i[0] && wb_dat_i[`SRT_PRESET_ECL]) begin
            next_st.up      = TW'(`SRT_ECL_UP);
            next_st.lo      = TW'(`SRT_ECL_LO);
            next_st.rate_go = 1'b1;
          end
        end
        // rate, status and trigger count ignore writes
        default: begin
        end
      endcase
    end else if (req) begin
      unique case (word)
        `SRT_OFS_CTRL:    next_st.rdat = ctrl_rd;
        `SRT_OFS_THR_UP:  next_st.rdat = 32'(st.up);
        `SRT_OFS_THR_LO:  next_st.rdat = 32'(st.lo);
        `SRT_OFS_DELTA:   next_st.rdat = 32'(st.delta);
        `SRT_OFS_RATE:    next_st.rdat = 32'(rif.quotient);
        `SRT_OFS_STATUS: begin
          next_st.rdat                 = 32'(st.last);
          next_st.rdat[`SRT_STAT_MEAS] = (st.meas != srt_pkg::S_WAIT);
          // also covers the cycle between a write and the divider's start
          next_st.rdat[`SRT_STAT_BUSY] = rif.busy | st.rate_go;
        end
        `SRT_OFS_TRIGCNT: next_st.rdat = 32'(st.ntrig);
        default:          next_st.rdat = 32'h0000_0000;
      endcase
    end

    // ----- edge qualifier on the selected channel
    cur     = {up_s[st.src], lo_s[st.src]};
    // prev follows the channel even while disabled, so enabling fakes no edge
    next_st.prev = cur;
    rise_ok = (st.pol == `SRT_POL_POS) || (st.pol == `SRT_POL_EITHER);
    fall_ok = (st.pol == `SRT_POL_NEG) || (st.pol == `SRT_POL_EITHER);

    // disabled or control register written: drop any edge being timed
    if (!st.en || abort) begin
      next_st.meas = srt_pkg::S_WAIT;
    end else begin
      unique case (st.meas)
        srt_pkg::S_WAIT: begin
          // a jump straight across both levels in one sample is too fast to time
          if (st.prev == RG_BELOW && cur == RG_MID && rise_ok) begin
            next_st.meas = srt_pkg::S_RISE;
            next_st.cnt  = CW'(1);
          end else if (st.prev == RG_ABOVE && cur == RG_MID && fall_ok) begin
            next_st.meas = srt_pkg::S_FALL;
            next_st.cnt  = CW'(1);
          end
        end
        srt_pkg::S_RISE, srt_pkg::S_FALL: begin
          if (cur == RG_MID) begin
            // saturate: a stalled edge stays slow instead of wrapping to fast
            if (st.cnt != '1) begin
              next_st.cnt = st.cnt + CW'(1);
            end
          end else if ((st.meas == srt_pkg::S_RISE && cur == RG_ABOVE) ||
                       (st.meas == srt_pkg::S_FALL && cur == RG_BELOW)) begin
            next_st.meas = srt_pkg::S_WAIT;
            next_st.last = st.cnt;
            // equal counts never trigger in either direction
            hit = st.slower ? (st.cnt > st.delta) : (st.cnt < st.delta);
            if (hit && st.cnt >= FAST_CYC) begin
              next_st.trig      = 1'b1;
              next_st.trig_fall = (st.meas == srt_pkg::S_FALL);
              // wraps; software reads it as a modulo counter
              next_st.ntrig     = st.ntrig + 16'h0001;
            end
          end else begin
            next_st.meas = srt_pkg::S_WAIT;
          end
        end
        default: begin
          next_st.meas = srt_pkg::S_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= RST;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ========================================================================
  // outputs straight from the state register
  assign wb_dat_o       = st.rdat;
  assign wb_ack_o       = st.ack;
  assign thr_upper_o    = st.up;
  assign thr_lower_o    = st.lo;
  assign trig_o         = st.trig;
  assign trig_falling_o = st.trig_fall;

endmodule : srt_slew_trigger

// ===== tb/srt_assertions.sv
// port-level checks of the slew-rate trigger
`include "srt_map.svh"
module srt_assertions #(
  parameter int TW = 16
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          ce_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic [TW-1:0] thr_upper_o,
  input wire logic [TW-1:0] thr_lower_o,
  input wire logic          trig_o,
  input wire logic          trig_falling_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i;
  // ==========================================================================
  // bus
  a_ack_after_req: assert property (req && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // ==========================================================================
  // thresholds and trigger
  a_rst_values: assert property ($past(rst_i) |-> thr_upper_o == `SRT_RST_UP
    && thr_lower_o == `SRT_RST_LO && !trig_o) else $error("bad values after reset");
  a_thr_on_ack: assert property (!$stable(thr_upper_o) || !$stable(thr_lower_o)
    |-> wb_ack_o) else $error("threshold moved without a write");
  a_thr_write: assert property (req && wb_we_i && !wb_ack_o && ce_i && wb_sel_i == 4'hF
    && wb_adr_i == `SRT_OFS_THR_UP |=> thr_upper_o == $past(wb_dat_i[15:0]))
    else $error("upper threshold write lost");
  a_trig_pulse: assert property (trig_o |=> !trig_o)
    else $error("trigger longer than one cycle");
  a_fall_with_trig: assert property (trig_falling_o |-> trig_o)
    else $error("falling flag without trigger");
endmodule : srt_assertions

// ===== tb/srt_cmp_model.sv
// threshold comparator pair per channel in front of the trigger pins
module srt_cmp_model (
  input  wire logic [15:0]      thr_upper_i,
  input  wire logic [15:0]      thr_lower_i,
  input  wire logic [3:0][15:0] lvl_i,
  output logic      [3:0]       cmp_upper_o,
  output logic      [3:0]       cmp_lower_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ideal comparators without hysteresis: the bench steps cleanly across levels
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      cmp_upper_o[c] = lvl_i[c] > thr_upper_i;
      cmp_lower_o[c] = lvl_i[c] > thr_lower_i;
    end
  end
endmodule : srt_cmp_model

// ===== tb/tb.sv
// self-checking bench of the slew-rate trigger
`include "srt_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_i, rst_i, ce_i, cyc, stb, we, ack, trig, fall, lastfall;
  logic [7:0]       adr;
  logic [3:0]       sel, cu, cl;
  logic [31:0]      dat_w, dat_r, rng;
  logic [15:0]      tu, tl;
  logic [3:0][15:0] lvl;
  int               num_errors, checked, ntrig, total;

  srt_slew_trigger dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .cmp_upper_i(cu), .cmp_lower_i(cl),
    .thr_upper_o(tu), .thr_lower_o(tl), .trig_o(trig), .trig_falling_o(fall));
  srt_cmp_model u_cmp (.thr_upper_i(tu), .thr_lower_i(tl), .lvl_i(lvl),
    .cmp_upper_o(cu), .cmp_lower_o(cl));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (trig === 1'b1) begin
    ntrig++;
    lastfall = fall;
  end

  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  function automatic logic [31:0] rate_exp(input logic [15:0] u, input logic [15:0] l,
                                           input logic [15:0] d);
    if (d == 16'h0) return 32'hFFFFFFFF;
    if (u <= l) return 32'h0;
    return {u - l, 16'h0} / {16'h0, d};
  endfunction : rate_exp
  function automatic logic trig_exp(input logic [1:0] p, input logic slow, input logic rise,
                                    input int n, input int d);
    logic ok;
    ok = (p == `SRT_POL_POS) ? rise : (p == `SRT_POL_NEG) ? !rise : (p == `SRT_POL_EITHER);
    return ok && n >= 1 && (slow ? n > d : n < d);
  endfunction : trig_exp

  // ==========================================================================
  // wishbone classic master
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_r;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, e, q);
  endtask : rdc
  task automatic wait_rate();
    logic [31:0] q;
    int n;
    n = 0;
    repeat (4) @(posedge clk_i);
    do begin
      wb(1'b0, `SRT_OFS_STATUS, 32'h0, 4'hF, q);
      n++;
    end while (q[`SRT_STAT_BUSY] !== 1'b0 && n < 40);
  endtask : wait_rate

  // ==========================================================================
  // one edge on channel ch; ab turns back before the second threshold
  task automatic trial(input int ch, input int src, input logic en, input logic [1:0] p,
                       input logic slow, input logic rise, input int n, input int d,
                       input logic ab);
    int t0;
    logic e;
    logic [15:0] lo_v, hi_v;
    t0 = ntrig;
    lo_v = rise ? 16'h1000 : 16'hF000;
    hi_v = rise ? 16'hF000 : 16'h1000;
    e = en && ch == src && !ab && trig_exp(p, slow, rise, n, d);
    lvl[ch] <= lo_v;
    wr(`SRT_OFS_DELTA, d);
    wr(`SRT_OFS_CTRL, {26'h0, slow, p, src[1:0], en});
    if (n > 0) begin
      lvl[ch] <= 16'h8000;
      repeat (n) @(posedge clk_i);
    end
    lvl[ch] <= ab ? lo_v : hi_v;
    repeat (6) @(posedge clk_i);
    chk("trigger count", {31'h0, e}, 32'(ntrig - t0));
    if (e) begin
      chk("trigger falling", {31'h0, !rise}, {31'h0, lastfall});
      // the delta write restarted the divider: let busy clear before reading
      wait_rate();
      rdc("transit count", `SRT_OFS_STATUS, 32'(n));
    end
    total += e;
  endtask : trial

  initial begin
    #(25ns * 20000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    time         t;
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
    lvl = '0;
    rng = 32'h1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("ctrl", `SRT_OFS_CTRL, 32'h0);
    rdc("thr up", `SRT_OFS_THR_UP, {16'h0, `SRT_RST_UP});
    rdc("thr lo", `SRT_OFS_THR_LO, {16'h0, `SRT_RST_LO});
    rdc("delta", `SRT_OFS_DELTA, {16'h0, `SRT_RST_DELTA});
    rdc("preset", `SRT_OFS_PRESET, 32'h0);
    rdc("unmapped", 8'h20, 32'h0);
    wait_rate();
    rdc("rate", `SRT_OFS_RATE, rate_exp(`SRT_RST_UP, `SRT_RST_LO, `SRT_RST_DELTA));
    wr(`SRT_OFS_RATE, 32'h12345678);
    rdc("rate ro", `SRT_OFS_RATE, rate_exp(`SRT_RST_UP, `SRT_RST_LO, `SRT_RST_DELTA));
    wr(`SRT_OFS_PRESET, 32'h2);
    chk("ecl", {`SRT_ECL_UP, `SRT_ECL_LO}, {tu, tl});
    wr(`SRT_OFS_PRESET, 32'h3);
    chk("ttl", {`SRT_TTL_UP, `SRT_TTL_LO}, {tu, tl});
    wait_rate();
    rdc("rate ttl", `SRT_OFS_RATE, rate_exp(`SRT_TTL_UP, `SRT_TTL_LO, `SRT_RST_DELTA));
    wr(`SRT_OFS_THR_UP, 32'h000090AA);
    // lane 1 only: the low byte written before must survive
    wb(1'b1, `SRT_OFS_THR_UP, 32'h0000C055, 4'h2, r);
    wr(`SRT_OFS_THR_LO, 32'h00004000);
    chk("lanes", {16'hC0AA, 16'h4000}, {tu, tl});
    // a request made while the clock enable is low must wait for it
    ce_i <= 1'b0;
    fork
      begin
        repeat (8) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join_none
    t = $time;
    wr(`SRT_OFS_DELTA, 32'h0000000A);
    chk("ce stall", 32'h1, {31'h0, ($time - t) >= 200ns});
    trial(0, 0, 1'b1, `SRT_POL_POS, 1'b0, 1'b1, 9, 10, 1'b0);
    trial(1, 1, 1'b1, `SRT_POL_POS, 1'b0, 1'b1, 10, 10, 1'b0);
    trial(2, 2, 1'b1, `SRT_POL_NEG, 1'b1, 1'b0, 11, 10, 1'b0);
    trial(3, 3, 1'b1, `SRT_POL_NEG, 1'b1, 1'b0, 10, 10, 1'b0);
    trial(0, 0, 1'b1, `SRT_POL_EITHER, 1'b0, 1'b0, 1, 2, 1'b0);
    trial(0, 0, 1'b1, `SRT_POL_EITHER, 1'b0, 1'b1, 0, 2, 1'b0);
    trial(1, 1, 1'b1, `SRT_POL_POS, 1'b0, 1'b1, 3, 10, 1'b1);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      trial((r[4:2] == 3'h0) ? int'(r[1:0] ^ 2'h1) : int'(r[1:0]), int'(r[1:0]),
            r[7:5] != 3'h0, r[9:8], r[10], r[11], int'(r[15:12]),
            1 + int'(r[19:16]) % 12, r[22:20] == 3'h0);
    end
    rdc("trigger total", `SRT_OFS_TRIGCNT, 32'(total));
    report_and_stop();
  end
endmodule : tb

bind srt_slew_trigger srt_assertions #(.TW(TW)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .thr_upper_o(thr_upper_o), .thr_lower_o(thr_lower_o),
  .trig_o(trig_o), .trig_falling_o(trig_falling_o));
